// ---- logic/dpsf_pkg.sv ----
// Shared constants, carrier types and timing for the flag-space host controller.
`default_nettype none
package dpsf_pkg;
  // Flag space geometry.
  localparam int unsigned FLAG_COUNT = 8;
  localparam int unsigned FLAG_IDX_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [FLAG_IDX_W-1:0] FLAG_IDX_FIRST = 3'h0;
  localparam logic [FLAG_IDX_W-1:0] FLAG_IDX_LAST = 3'h7;

  // Flag levels: a zero asks for or shows a held token, a one frees it.
  localparam logic FLAG_TAKE = 1'b0;
  localparam logic FLAG_FREE = 1'b1;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
  localparam logic [DATA_W-1:0] ALL_ZEROS = 8'h00;

  // Pin timing, in nanoseconds, and the system clock rate.
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned T_SETUP_NS = 10;
  localparam int unsigned T_STROBE_NS = 50;
  localparam int unsigned T_GAP_NS = 25;

  // Least times round up to whole cycles and never fall below one.
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CNT_W = 8;
  localparam int unsigned SETUP_CYC = ns_to_cyc(T_SETUP_NS);
  localparam int unsigned STROBE_CYC = ns_to_cyc(T_STROBE_NS);
  localparam int unsigned GAP_CYC = ns_to_cyc(T_GAP_NS);

  // User commands.
  typedef enum logic [1:0] {OP_ACQUIRE, OP_RELEASE, OP_INIT, OP_PEEK} dpsf_op_type;

  typedef struct packed {
    dpsf_op_type op;
    logic [FLAG_IDX_W-1:0] idx;
  } dpsf_cmd_type;

  typedef struct packed {
    logic granted;
    logic [DATA_W-1:0] value;
  } dpsf_rsp_type;

  // Port pins of one side of the shared memory.
  typedef struct packed {
    logic semaphore_select_n;
    logic port_select_n;
    logic rw_n;
    logic oe_n;
    logic [FLAG_IDX_W-1:0] flag_index_lines;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } dpsf_pins_type;

  localparam dpsf_pins_type PINS_IDLE = '{semaphore_select_n: 1'b1, port_select_n: 1'b1, rw_n: 1'b1,
                                           oe_n: 1'b1, flag_index_lines: 3'h0, data_out: 8'h00, data_oe: 1'b0};
endpackage
`default_nettype wire

// ---- logic/dpsf_pin_seq.sv ----
// Pin sequencer that runs one read or write access in the flag space.
`default_nettype none
module dpsf_pin_seq
  import dpsf_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Access request and result.
  input wire logic start,
  input wire logic wr,
  input wire logic [FLAG_IDX_W-1:0] idx,
  input wire logic wbit,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // Port pins.
  input wire logic [DATA_W-1:0] data_in,
  output dpsf_pins_type pins
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_GAP} dpsf_phase_type;

  dpsf_phase_type phase_r, phase_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  dpsf_pins_type pins_r, pins_nxt;

  // Setup, strobe and gap phases; the gap always drops both selects so each read is latched afresh.
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    pins_nxt = pins_r;
    case (phase_r)
      P_IDLE: begin
        if (start) begin
          phase_nxt = P_SETUP;
          cnt_nxt = CNT_W'(SETUP_CYC - 1);
          wr_nxt = wr;
          pins_nxt.semaphore_select_n = 1'b0;
          pins_nxt.port_select_n = 1'b1;
          pins_nxt.flag_index_lines = idx;
          pins_nxt.data_out = {DATA_W{wbit}};
          pins_nxt.data_oe = wr;
        end
      end
      P_SETUP: begin
        if (cnt_r == '0) begin
          phase_nxt = P_STROBE;
          cnt_nxt = CNT_W'(STROBE_CYC - 1);
          if (wr_r) begin
            pins_nxt.rw_n = 1'b0;
          end else begin
            pins_nxt.oe_n = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      P_STROBE: begin
        if (cnt_r == '0) begin
          phase_nxt = P_GAP;
          cnt_nxt = CNT_W'(GAP_CYC - 1);
          if (!wr_r) begin
            rdata_nxt = data_in;
          end
          pins_nxt = PINS_IDLE;
          pins_nxt.flag_index_lines = pins_r.flag_index_lines;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      P_GAP: begin
        if (cnt_r == '0) begin
          phase_nxt = P_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        phase_nxt = P_IDLE;
        pins_nxt = PINS_IDLE;
      end
    endcase
  end

  // State registers; the clock enable freezes everything.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_r <= P_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= ALL_ONES;
      pins_r <= PINS_IDLE;
    end else if (ce) begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign done = done_r;
  assign rdata = rdata_r;
  assign pins = pins_r;

  // Checks on the pin protocol.
  a_port_sel_off: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    !pins_r.semaphore_select_n |-> pins_r.port_select_n)
    else $error("Memory port select active during a flag access.");
  a_strobe_in_space: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    (!pins_r.rw_n || !pins_r.oe_n) |-> (!pins_r.semaphore_select_n && $past(!pins_r.semaphore_select_n)))
    else $error("Strobe without a settled flag-space select.");
  a_write_data_form: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    !pins_r.rw_n |-> (pins_r.data_oe && (pins_r.data_out == ALL_ONES || pins_r.data_out == ALL_ZEROS)))
    else $error("Write strobe without a driven flag level.");
  a_read_gap_drop: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    $fell(pins_r.oe_n) |-> ##[1:64] (pins_r.oe_n && pins_r.semaphore_select_n))
    else $error("Read strobe not followed by a deselect.");
  c_read_strobe: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(pins_r.oe_n));
endmodule
`default_nettype wire

// ---- logic/dpsf_host.sv ----
// Host controller that takes, releases and initialises flags through one port's pins.
//
// How it works
// - Access flags with flag select low, normal strobes.
// - Write zero to request, one to release.
// - Write zero first, then read back to check.
// - After failure keep reading or withdraw with one.
// - Drop select or enable between polling reads.
// - Write one to every flag at initialisation.
// - Keep memory port select off during flag access.
`default_nettype none
module dpsf_host
  import dpsf_pkg::*;
#(
  parameter int unsigned POLL_LIMIT = 16
) (
  // Clock, reset and freeze.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // User command channel.
  input wire logic cmd_valid,
  input wire dpsf_cmd_type cmd,
  output logic cmd_ready,
  // User response channel and ownership view.
  output logic rsp_valid,
  output dpsf_rsp_type rsp,
  output logic [FLAG_COUNT-1:0] owned,
  // Port pins toward the shared memory.
  input wire logic [DATA_W-1:0] data_in,
  output dpsf_pins_type pins
);
  localparam int unsigned POLL_W = $clog2(POLL_LIMIT + 1);

  typedef enum logic [2:0] {
    S_IDLE, S_INIT_WR, S_ACQ_WR, S_ACQ_RD, S_WITHDRAW, S_REL_WR, S_PEEK_RD
  } dpsf_state_type;

  // True in every state that runs a pin access.
  function automatic logic is_access(input dpsf_state_type s);
    return s != S_IDLE;
  endfunction

  // True in states whose access is a write.
  function automatic logic is_write(input dpsf_state_type s);
    return s == S_INIT_WR || s == S_ACQ_WR || s == S_WITHDRAW || s == S_REL_WR;
  endfunction

  dpsf_state_type state_r, state_nxt;
  logic [FLAG_IDX_W-1:0] idx_r, idx_nxt;
  logic [POLL_W-1:0] poll_r, poll_nxt;
  logic issued_r, issued_nxt;
  logic ready_r, ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  dpsf_rsp_type rsp_r, rsp_nxt;
  logic [FLAG_COUNT-1:0] owned_r, owned_nxt;
  logic start;
  logic wr;
  logic wbit;
  logic done;
  logic rbit;
  logic [DATA_W-1:0] rdata;

  // One access is launched per state visit; a repeat visit relaunches after done.
  assign start = is_access(state_r) && !issued_r;
  assign wr = is_write(state_r);
  assign wbit = (state_r == S_ACQ_WR) ? FLAG_TAKE : FLAG_FREE;
  assign rbit = rdata[0];

  dpsf_pin_seq u_pin_seq (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .start(start),
    .wr(wr),
    .idx(idx_r),
    .wbit(wbit),
    .done(done),
    .rdata(rdata),
    .data_in(data_in),
    .pins(pins)
  );

  // Command sequencing. The request is a write followed by read-back, never the other way,
  // because a read first would leave a window in which the other port could slip in.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    poll_nxt = poll_r;
    owned_nxt = owned_r;
    rsp_nxt = rsp_r;
    rsp_valid_nxt = 1'b0;
    issued_nxt = issued_r;
    if (start) begin
      issued_nxt = 1'b1;
    end
    if (done) begin
      issued_nxt = 1'b0;
    end
    case (state_r)
      S_IDLE: begin
        if (cmd_valid && ready_r) begin
          idx_nxt = cmd.idx;
          poll_nxt = '0;
          case (cmd.op)
            OP_ACQUIRE: state_nxt = S_ACQ_WR;
            OP_RELEASE: state_nxt = S_REL_WR;
            OP_PEEK: state_nxt = S_PEEK_RD;
            default: begin
              state_nxt = S_INIT_WR;
              idx_nxt = FLAG_IDX_FIRST;
            end
          endcase
        end
      end
      S_INIT_WR: begin
        if (done) begin
          if (idx_r == FLAG_IDX_LAST) begin
            state_nxt = S_IDLE;
            owned_nxt = '0;
            rsp_valid_nxt = 1'b1;
            rsp_nxt = '{granted: 1'b0, value: rdata};
          end else begin
            idx_nxt = idx_r + 1'b1;
          end
        end
      end
      S_ACQ_WR: begin
        if (done) begin
          state_nxt = S_ACQ_RD;
        end
      end
      S_ACQ_RD: begin
        if (done) begin
          if (rbit == FLAG_TAKE) begin
            state_nxt = S_IDLE;
            owned_nxt[idx_r] = 1'b1;
            rsp_valid_nxt = 1'b1;
            rsp_nxt = '{granted: 1'b1, value: rdata};
          end else if (poll_r == POLL_W'(POLL_LIMIT - 1)) begin
            state_nxt = S_WITHDRAW;
          end else begin
            poll_nxt = poll_r + 1'b1;
          end
        end
      end
      S_WITHDRAW: begin
        if (done) begin
          state_nxt = S_IDLE;
          rsp_valid_nxt = 1'b1;
          rsp_nxt = '{granted: 1'b0, value: rdata};
        end
      end
      S_REL_WR: begin
        if (done) begin
          state_nxt = S_IDLE;
          owned_nxt[idx_r] = 1'b0;
          rsp_valid_nxt = 1'b1;
          rsp_nxt = '{granted: 1'b0, value: rdata};
        end
      end
      S_PEEK_RD: begin
        if (done) begin
          state_nxt = S_IDLE;
          rsp_valid_nxt = 1'b1;
          rsp_nxt = '{granted: owned_r[idx_r], value: rdata};
        end
      end
      default: begin
        state_nxt = S_IDLE;
        issued_nxt = 1'b0;
      end
    endcase
    ready_nxt = (state_nxt == S_IDLE);
  end

  // Registers; the clock enable freezes the whole controller.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      idx_r <= FLAG_IDX_FIRST;
      poll_r <= '0;
      issued_r <= 1'b0;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
      owned_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      poll_r <= poll_nxt;
      issued_r <= issued_nxt;
      ready_r <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
      owned_r <= owned_nxt;
    end
  end

  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign owned = owned_r;

  // Checks on the request discipline.
  a_write_then_read: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    (start && wr && wbit == FLAG_TAKE) |-> ##[1:64] (start && !wr && state_r == S_ACQ_RD))
    else $error("Request write not followed by a read-back.");
  a_fail_withdraw: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    (state_r == S_ACQ_RD && done && rbit == FLAG_FREE && poll_r == POLL_W'(POLL_LIMIT - 1))
    |=> (start && wr && wbit == FLAG_FREE))
    else $error("Failed request not withdrawn with a one.");
  a_init_writes_one: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    (state_r == S_INIT_WR && start) |-> (wr && wbit == FLAG_FREE))
    else $error("Initialisation wrote something other than a one.");
  a_grant_on_zero: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    (state_r == S_ACQ_RD && done && rbit == FLAG_TAKE) |=> (rsp_valid_r && rsp_r.granted && owned_r[$past(idx_r)]))
    else $error("Zero read-back did not report a grant.");
  c_grant: cover property (@(posedge clk_sys) disable iff (!resetn) rsp_valid_r && rsp_r.granted);
  c_withdraw: cover property (@(posedge clk_sys) disable iff (!resetn) state_r == S_WITHDRAW && done);
  c_init_done: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_r == S_INIT_WR && done && idx_r == FLAG_IDX_LAST);
  c_release: cover property (@(posedge clk_sys) disable iff (!resetn) state_r == S_REL_WR && done);
endmodule
`default_nettype wire

// ---- dv/dpsf_dev_model.sv ----
// Behavioural model of the shared memory's flag space, left port on pins, right port from the bench.
`default_nettype none
module dpsf_dev_model
  import dpsf_pkg::*;
(
  // Sampling clock.
  input wire logic clk_sys,
  // Left port pins.
  input wire dpsf_pins_type pins,
  output logic [DATA_W-1:0] data_in,
  // Right port, one write per clock.
  input wire logic r_we,
  input wire logic [FLAG_IDX_W-1:0] r_idx,
  input wire logic r_bit,
  output logic [FLAG_COUNT-1:0] r_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // Request latches start dirty on purpose, since nothing clears them at power-up.
  logic [FLAG_COUNT-1:0] req_l = 8'ha5;
  logic [FLAG_COUNT-1:0] req_r = 8'h3c;
  logic [FLAG_COUNT-1:0] own_l = 8'h00;
  logic [FLAG_COUNT-1:0] own_r = 8'h00;
  logic lat = 1'b1;
  logic last = 1'b0;
  wire logic act = ~pins.semaphore_select_n & ~pins.oe_n & pins.rw_n;

  // Only an owner's own latch frees a flag; a freed flag goes to a waiting side at once, left first.
  task automatic settle();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
      if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
      if (!own_l[i] && !own_r[i]) begin
        if (!req_l[i]) own_l[i] = 1'b1;
        else if (!req_r[i]) own_r[i] = 1'b1;
      end
    end
  endtask

  initial settle();

  // Writes land in the writer's latch only; the flags gate no memory access.
  always @(posedge clk_sys) begin
    if (!pins.semaphore_select_n && !pins.rw_n && pins.data_oe) begin
      req_l[pins.flag_index_lines] = pins.data_out[0];
    end
    if (r_we) req_r[r_idx] = r_bit;
    settle();
  end

  // The read value is frozen when select and enable both go active, so a stale poll stays stale.
  always @(posedge act) lat = ~own_l[pins.flag_index_lines];
  always @(negedge act) last = lat;
  // A released bus shows the inverse of the last value rather than a lucky match.
  assign data_in = act ? {DATA_W{lat}} : {DATA_W{~last}};
  assign r_flags = ~own_r;
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the flag-space host controller against the device model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsf_pkg::*;
  localparam int DLY = 2;
  typedef struct {
    logic [1:0] ract;
    dpsf_op_type op;
    logic [2:0] idx;
    logic g;
    logic [7:0] v;
    logic cv;
    logic rf;
  } dpsf_row_type;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  dpsf_cmd_type cmd = '{OP_PEEK, 3'h0};
  logic cmd_ready;
  logic rsp_valid;
  dpsf_rsp_type rsp;
  dpsf_rsp_type got;
  logic [FLAG_COUNT-1:0] owned;
  logic [FLAG_COUNT-1:0] r_flags;
  logic [DATA_W-1:0] data_in;
  dpsf_pins_type pins;
  dpsf_pins_type held;
  logic r_we = 1'b0;
  logic [2:0] r_idx = 3'h0;
  logic r_bit = 1'b1;
  int num_errors = 0;
  int samples_checked = 0;
  // Right-port action (10 take, 11 free) runs before each command.
  dpsf_row_type rows [11] = '{
    '{2'b00, OP_ACQUIRE, 3'h3, 1'b1, 8'h00, 1'b1, 1'b1}, '{2'b00, OP_PEEK, 3'h3, 1'b1, 8'h00, 1'b1, 1'b1},
    '{2'b10, OP_PEEK, 3'h3, 1'b1, 8'h00, 1'b1, 1'b1}, '{2'b00, OP_RELEASE, 3'h3, 1'b0, 8'h00, 1'b0, 1'b0},
    '{2'b00, OP_PEEK, 3'h3, 1'b0, 8'hff, 1'b1, 1'b0}, '{2'b00, OP_ACQUIRE, 3'h3, 1'b0, 8'hff, 1'b1, 1'b0},
    '{2'b11, OP_PEEK, 3'h3, 1'b0, 8'hff, 1'b1, 1'b1}, '{2'b00, OP_ACQUIRE, 3'h7, 1'b1, 8'h00, 1'b1, 1'b1},
    '{2'b00, OP_ACQUIRE, 3'h0, 1'b1, 8'h00, 1'b1, 1'b1}, '{2'b00, OP_RELEASE, 3'h7, 1'b0, 8'h00, 1'b0, 1'b1},
    '{2'b10, OP_PEEK, 3'h7, 1'b0, 8'hff, 1'b1, 1'b0}};

  always #12.5 clk_sys = ~clk_sys;

  // Small poll limit keeps failed takes short.
  dpsf_host #(.POLL_LIMIT(4)) dpsf_host_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .owned(owned), .data_in(data_in), .pins(pins));
  dpsf_dev_model dpsf_dev_model_inst (.clk_sys(clk_sys), .pins(pins), .data_in(data_in), .r_we(r_we), .r_idx(r_idx),
    .r_bit(r_bit), .r_flags(r_flags));

  task automatic chk_rsp(input logic g, input logic [7:0] v, input logic cv);
    samples_checked++;
    if (got.granted !== g || (cv && got.value !== v)) begin
      num_errors++;
      $display("Error at %0t: response %h, expected %b/%h", $time, got, g, v);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string what);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: %s is %b, expected %b", $time, what, g, e);
    end
  endtask

  task automatic chk_pins(input dpsf_pins_type e);
    samples_checked++;
    if (pins !== e) begin
      num_errors++;
      $display("Error at %0t: pins %h, expected %h", $time, pins, e);
    end
  endtask

  // Offer one command, then wait a bounded time for its answer.
  task automatic do_cmd(input dpsf_op_type op, input logic [2:0] idx);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #DLY;
      n++;
    end
    cmd_valid = 1'b1;
    cmd = '{op, idx};
    @(posedge clk_sys);
    #DLY;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #DLY;
      n++;
    end
    if (n == 2000) begin
      num_errors++;
      $display("Error at %0t: no response", $time);
    end
    got = rsp;
  endtask

  task automatic r_op(input logic b, input logic [2:0] i);
    r_we = 1'b1;
    r_idx = i;
    r_bit = b;
    @(posedge clk_sys);
    #DLY;
    r_we = 1'b0;
    // One idle edge keeps back-to-back writes from raising the strobe again in the same time step.
    @(posedge clk_sys);
    #DLY;
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // The memory array select must never move.
  always @(posedge clk_sys) begin
    if (resetn === 1'b1 && pins.port_select_n !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: memory select driven", $time);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #DLY;
    resetn = 1'b1;
    // Both sides free every flag before use.
    do_cmd(OP_INIT, 3'h0);
    for (int i = 0; i < 8; i++) r_op(1'b1, i[2:0]);
    chk_bit(r_flags[0] & (&r_flags), 1'b1, "right flags");
    for (int i = 0; i < 8; i++) begin
      do_cmd(OP_PEEK, i[2:0]);
      chk_rsp(1'b0, 8'hff, 1'b1);
    end
    foreach (rows[k]) begin
      if (rows[k].ract[1]) r_op(rows[k].ract[0], rows[k].idx);
      do_cmd(rows[k].op, rows[k].idx);
      chk_rsp(rows[k].g, rows[k].v, rows[k].cv);
      chk_bit(owned[rows[k].idx], rows[k].g, "owned");
      chk_bit(r_flags[rows[k].idx], rows[k].rf, "right flag");
    end
    // Right holds flag 5 and frees it mid-poll; only a fresh capture sees the handover.
    r_op(1'b0, 3'h5);
    fork
      do_cmd(OP_ACQUIRE, 3'h5);
      begin
        repeat (14) @(posedge clk_sys);
        #DLY;
        r_op(1'b1, 3'h5);
      end
    join
    chk_rsp(1'b1, 8'h00, 1'b1);
    // Freeze mid-access: pins and answer hold still.
    fork
      do_cmd(OP_PEEK, 3'h4);
      begin
        repeat (3) @(posedge clk_sys);
        #DLY;
        ce = 1'b0;
        held = pins;
        repeat (6) begin
          @(posedge clk_sys);
          #DLY;
          chk_pins(held);
          chk_bit(rsp_valid, 1'b0, "frozen answer");
        end
        ce = 1'b1;
      end
    join
    chk_rsp(1'b0, 8'hff, 1'b1);
    // Reset in the middle of a take, then clean up the flag.
    cmd_valid = 1'b1;
    cmd = '{OP_ACQUIRE, 3'h2};
    @(posedge clk_sys);
    #DLY;
    cmd_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    #DLY;
    resetn = 1'b0;
    #1;
    chk_pins(PINS_IDLE);
    chk_bit(|owned | rsp_valid | cmd_ready, 1'b0, "reset outputs");
    @(posedge clk_sys);
    #DLY;
    resetn = 1'b1;
    // A host reset does not free the device's flag, so it still reads as held until released.
    do_cmd(OP_PEEK, 3'h2);
    chk_rsp(1'b0, 8'h00, 1'b1);
    do_cmd(OP_RELEASE, 3'h2);
    chk_bit(r_flags[2], 1'b1, "freed flag");
    do_cmd(OP_PEEK, 3'h2);
    chk_rsp(1'b0, 8'hff, 1'b1);
    do_cmd(OP_ACQUIRE, 3'h0);
    chk_rsp(1'b1, 8'h00, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
